// ### logic/kps_consts.svh
// Constants of the keyed loop-source and status block: offsets, keys, fields, resets, timing
`ifndef KPS_CONSTS_SVH
`define KPS_CONSTS_SVH

// ==========================================================
// Register byte addresses
`define KPS_ADDR_LOCK_STATUS    32'hFFFF0400
`define KPS_ADDR_POWER_PREKEY   32'hFFFF0404
`define KPS_ADDR_POWER_CONTROL  32'hFFFF0408
`define KPS_ADDR_POWER_POSTKEY  32'hFFFF040C
`define KPS_ADDR_SRC_PREKEY     32'hFFFF0410
`define KPS_ADDR_SRC_SELECT     32'hFFFF0414
`define KPS_ADDR_SRC_POSTKEY    32'hFFFF0418
`define KPS_ADDR_IRQ_MASK       32'hFFFF041C
`define KPS_ADDR_LOCK_LATE      32'hFFFF0420

// ==========================================================
// Key values
`define KPS_KEY_SRC_PRE         32'h000000AA
`define KPS_KEY_SRC_POST        32'h00000055
`define KPS_KEY_POWER_PRE       32'h00000001
`define KPS_KEY_POWER_POST      32'h000000F4

// ==========================================================
// Status fields
`define KPS_STA_LOSS_BIT        0
`define KPS_STA_LOCK_BIT        1
`define KPS_STA_XTAL_BIT        2
`define KPS_SRC_CODE_RESERVED   2'h3

// ==========================================================
// Reset values
`define KPS_RST_SRC_SELECT      8'h00
`define KPS_RST_POWER_CONTROL   8'h79
`define KPS_RST_IRQ_MASK        1'h0

// ==========================================================
// Timing: lock bound in ms, clock in kHz, bound in cycles
`define KPS_LOCK_TIME_MS        2
`define KPS_CLK_FREQ_KHZ        100000
`define KPS_LOCK_CYCLES         (`KPS_LOCK_TIME_MS * `KPS_CLK_FREQ_KHZ)
`define KPS_LOCK_CNT_W          18

`endif

// ### logic/kps_pkg.sv
// Types of the keyed loop-source and status block
package kps_pkg;

   // ==========================================================
   // Progress of one keyed write sequence
   typedef enum logic [1:0] {
      KPS_KEY_IDLE,
      KPS_KEY_ARMED,
      KPS_KEY_STAGED
   } kps_key_state_t;

   // ==========================================================
   // Loop reference source codes
   typedef enum logic [1:0] {
      KPS_SRC_LOW_POWER = 2'h0,
      KPS_SRC_PRECISION = 2'h1,
      KPS_SRC_CRYSTAL   = 2'h2
   } kps_source_t;

endpackage : kps_pkg

// ### logic/kps_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module kps_sync (
   // Clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // Asynchronous pin and its filtered level
   input  wire logic pin_async,
   output var  logic level
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ==========================================================
   // Chain; level follows once stages two and three agree
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_q <= pin_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end

endmodule : kps_sync
`default_nettype wire

// ### logic/kps_top.sv
// Keyed loop-source select, keyed power control and loop status over AHB-Lite
`timescale 1ns/10ps
`default_nettype none
`include "kps_consts.svh"

module kps_top #(
   parameter int unsigned LOCK_CYCLES = `KPS_LOCK_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // Pins and loop
   input  wire logic        crystal_input_pin,
   input  wire logic        pll_lock_raw,
   // Clock system controls
   output var  logic [1:0]  pll_ref_sel,
   output var  logic [7:0]  power_control,
   output var  logic        pll_lock_late,
   // Interrupt
   output var  logic        irq
);

   // ==========================================================
   // Helpers
   function automatic logic kps_is(input logic [31:0] a, input logic [31:0] off);
      kps_is = (a == off);
   endfunction : kps_is

   function automatic kps_pkg::kps_key_state_t kps_key_next(
      input kps_pkg::kps_key_state_t st,
      input logic                    hit_pre,
      input logic                    hit_reg,
      input logic                    hit_post,
      input logic                    pre_ok);
      kps_key_next = st;
      if (hit_pre) begin
         kps_key_next = pre_ok ? kps_pkg::KPS_KEY_ARMED : kps_pkg::KPS_KEY_IDLE;
      end else if (hit_reg) begin
         case (st)
            kps_pkg::KPS_KEY_ARMED: kps_key_next = kps_pkg::KPS_KEY_STAGED;
            default:                kps_key_next = kps_pkg::KPS_KEY_IDLE;
         endcase
      end else if (hit_post) begin
         kps_key_next = kps_pkg::KPS_KEY_IDLE;
      end
   endfunction : kps_key_next

   // ==========================================================
   // Bus phase tracking
   logic [31:0] addr_q;
   logic        wr_q;
   logic        rd_q;
   logic [31:0] rdata;
   wire         addr_take = hsel & hready & htrans[1];
   wire         rd_take   = addr_take & ~hwrite;
   wire         hsize_ok  = (hsize == 3'h2);   // Only word writes are used; reads of any size are served

   // Address phase capture; reads take one wait state
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addr_q    <= 32'h0;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0;
         hresp     <= 1'b0;
      end else begin
         if (addr_take) begin
            addr_q <= haddr;
         end
         wr_q      <= addr_take & hwrite & hsize_ok;
         rd_q      <= rd_take;
         hreadyout <= rd_q | ~rd_take;
         if (rd_q) begin
            hrdata <= rdata;
         end
      end
   end

   // ==========================================================
   // Write decode in the data phase
   wire w_sta   = wr_q & kps_is(addr_q, `KPS_ADDR_LOCK_STATUS);
   wire w_ppre  = wr_q & kps_is(addr_q, `KPS_ADDR_POWER_PREKEY);
   wire w_pow   = wr_q & kps_is(addr_q, `KPS_ADDR_POWER_CONTROL);
   wire w_ppost = wr_q & kps_is(addr_q, `KPS_ADDR_POWER_POSTKEY);
   wire w_spre  = wr_q & kps_is(addr_q, `KPS_ADDR_SRC_PREKEY);
   wire w_src   = wr_q & kps_is(addr_q, `KPS_ADDR_SRC_SELECT);
   wire w_spost = wr_q & kps_is(addr_q, `KPS_ADDR_SRC_POSTKEY);
   wire w_mask  = wr_q & kps_is(addr_q, `KPS_ADDR_IRQ_MASK);
   wire w_late  = wr_q & kps_is(addr_q, `KPS_ADDR_LOCK_LATE);

   // ==========================================================
   // Keyed sequences
   kps_pkg::kps_key_state_t src_st_q;
   kps_pkg::kps_key_state_t pow_st_q;
   logic [7:0]              src_stage_q;
   logic [7:0]              pow_stage_q;
   logic [7:0]              src_q;
   logic [7:0]              pow_q;

   wire src_pre_ok  = (hwdata == `KPS_KEY_SRC_PRE);
   wire pow_pre_ok  = (hwdata == `KPS_KEY_POWER_PRE);
   wire src_commit  = w_spost & (src_st_q == kps_pkg::KPS_KEY_STAGED)
                      & (hwdata == `KPS_KEY_SRC_POST);
   wire pow_commit  = w_ppost & (pow_st_q == kps_pkg::KPS_KEY_STAGED)
                      & (hwdata == `KPS_KEY_POWER_POST);
   wire src_code_ok = (src_stage_q[1:0] != `KPS_SRC_CODE_RESERVED);
   wire src_stage   = w_src & (src_st_q == kps_pkg::KPS_KEY_ARMED);
   wire pow_stage   = w_pow & (pow_st_q == kps_pkg::KPS_KEY_ARMED);
   wire src_apply   = src_commit & src_code_ok;

   // Sequence states
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         src_st_q <= kps_pkg::KPS_KEY_IDLE;
         pow_st_q <= kps_pkg::KPS_KEY_IDLE;
      end else begin
         src_st_q <= kps_key_next(src_st_q, w_spre, w_src, w_spost, src_pre_ok);
         pow_st_q <= kps_key_next(pow_st_q, w_ppre, w_pow, w_ppost, pow_pre_ok);
      end
   end

   // Staged values and committed registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         src_stage_q <= `KPS_RST_SRC_SELECT;
         pow_stage_q <= `KPS_RST_POWER_CONTROL;
         src_q       <= `KPS_RST_SRC_SELECT;
         pow_q       <= `KPS_RST_POWER_CONTROL;
      end else begin
         if (src_stage) src_stage_q <= hwdata[7:0];
         if (pow_stage) pow_stage_q <= hwdata[7:0];
         if (src_apply) src_q <= src_stage_q;
         if (pow_commit) pow_q <= pow_stage_q;
      end
   end

   // Drive the clock system from committed values
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pll_ref_sel   <= kps_pkg::KPS_SRC_LOW_POWER;
         power_control <= `KPS_RST_POWER_CONTROL;
      end else begin
         pll_ref_sel   <= src_q[1:0];
         power_control <= pow_q;
      end
   end

   // ==========================================================
   // Pin inputs
   logic xtal_lvl;
   logic lock_lvl;
   logic lock_prev_q;

   kps_sync u_xtal_sync (
      .clock     (clock),
      .arst_n    (arst_n),
      .pin_async (crystal_input_pin),
      .level     (xtal_lvl)
   );

   kps_sync u_lock_sync (
      .clock     (clock),
      .arst_n    (arst_n),
      .pin_async (pll_lock_raw),
      .level     (lock_lvl)
   );

   // ==========================================================
   // Loss flag, lock watch, mask, interrupt
   logic                      loss_q;
   logic                      late_q;
   logic                      mask_q;
   logic [`KPS_LOCK_CNT_W-1:0] lock_cnt_q;

   wire lock_fall = lock_prev_q & ~lock_lvl;
   wire loss_d    = lock_fall | (loss_q & ~(w_sta & hwdata[`KPS_STA_LOSS_BIT]));
   wire late_hit  = ~lock_lvl & (lock_cnt_q == LOCK_CYCLES[`KPS_LOCK_CNT_W-1:0] - 1'b1);
   wire late_d    = late_hit | (late_q & ~(w_late & hwdata[0]));

   // Sticky flags, set beats clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_prev_q <= 1'b0;
         loss_q      <= 1'b0;
         late_q      <= 1'b0;
         mask_q      <= `KPS_RST_IRQ_MASK;
      end else begin
         lock_prev_q <= lock_lvl;
         loss_q      <= loss_d;
         late_q      <= late_d;
         if (w_mask) mask_q <= hwdata[0];
      end
   end

   // Lock wait counter, restarted by lock or a new source
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_cnt_q <= '0;
      end else if (lock_lvl || src_apply) begin
         lock_cnt_q <= '0;
      end else if (!late_hit && !late_q) begin
         lock_cnt_q <= lock_cnt_q + 1'b1;
      end
   end

   // Registered outputs of the flags
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq           <= 1'b0;
         pll_lock_late <= 1'b0;
      end else begin
         irq           <= loss_q & mask_q;
         pll_lock_late <= late_q;
      end
   end

   // ==========================================================
   // Read data select; keys read as zero
   wire [7:0] status = {5'h00, xtal_lvl, lock_lvl, loss_q};
   wire r_sta  = kps_is(addr_q, `KPS_ADDR_LOCK_STATUS);
   wire r_src  = kps_is(addr_q, `KPS_ADDR_SRC_SELECT);
   wire r_pow  = kps_is(addr_q, `KPS_ADDR_POWER_CONTROL);
   wire r_mask = kps_is(addr_q, `KPS_ADDR_IRQ_MASK);
   wire r_late = kps_is(addr_q, `KPS_ADDR_LOCK_LATE);

   assign rdata = r_sta  ? {24'h000000, status} :
                  r_src  ? {24'h000000, src_q}  :
                  r_pow  ? {24'h000000, pow_q}  :
                  r_mask ? {31'h00000000, mask_q} :
                  r_late ? {31'h00000000, late_q} : 32'h00000000;

   // ==========================================================
   // Checks
   sequence s_src_keyed;
      (src_st_q == kps_pkg::KPS_KEY_STAGED) && w_spost && (hwdata == `KPS_KEY_SRC_POST);
   endsequence

   property p_src_keyed;
      @(posedge clock) disable iff (!arst_n)
      (src_q != $past(src_q)) |-> $past(src_commit);
   endproperty
   a_src_keyed: assert property (p_src_keyed) else $error("source changed without keys");

   property p_src_commit;
      @(posedge clock) disable iff (!arst_n)
      s_src_keyed ##0 (src_stage_q[1:0] != 2'h3) |=> (src_q == $past(src_stage_q));
   endproperty
   a_src_commit: assert property (p_src_commit) else $error("source not committed");

   property p_pow_keyed;
      @(posedge clock) disable iff (!arst_n)
      (pow_q != $past(pow_q)) |-> $past(pow_commit);
   endproperty
   a_pow_keyed: assert property (p_pow_keyed) else $error("power changed without keys");

   property p_pre_arm;
      @(posedge clock) disable iff (!arst_n)
      (w_spre && hwdata == `KPS_KEY_SRC_PRE) |=> (src_st_q == kps_pkg::KPS_KEY_ARMED);
   endproperty
   a_pre_arm: assert property (p_pre_arm) else $error("pre-key did not arm");

   property p_xtal_live;
      @(posedge clock) disable iff (!arst_n)
      crystal_input_pin [*5] |-> status[`KPS_STA_XTAL_BIT];
   endproperty
   a_xtal_live: assert property (p_xtal_live) else $error("crystal bit stale");

   property p_lock_bit;
      @(posedge clock) disable iff (!arst_n)
      !pll_lock_raw [*5] |-> !status[`KPS_STA_LOCK_BIT];
   endproperty
   a_lock_bit: assert property (p_lock_bit) else $error("lock bit set while unlocked");

   property p_loss_set;
      @(posedge clock) disable iff (!arst_n)
      $fell(lock_lvl) |=> loss_q ##1 (irq == $past(mask_q));
   endproperty
   a_loss_set: assert property (p_loss_set) else $error("loss flag not set");

   property p_loss_clear;
      @(posedge clock) disable iff (!arst_n)
      (w_sta && !hwdata[0] && loss_q) |=> loss_q;
   endproperty
   a_loss_clear: assert property (p_loss_clear) else $error("zero write cleared flag");

   property p_status_resv;
      @(posedge clock) disable iff (!arst_n)
      (rd_q && r_sta) |=> (hrdata[31:3] == 29'h0);
   endproperty
   a_status_resv: assert property (p_status_resv) else $error("reserved status bits set");

   property p_ref_sel;
      @(posedge clock) disable iff (!arst_n)
      1'b1 |=> (pll_ref_sel == $past(src_q[1:0]));
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("source select not driven");

   property p_late;
      @(posedge clock) disable iff (!arst_n)
      late_hit |=> late_q ##1 pll_lock_late;
   endproperty
   a_late: assert property (p_late) else $error("late lock not flagged");

   property p_unkeyed;
      @(posedge clock) disable iff (!arst_n)
      (w_src && src_st_q != kps_pkg::KPS_KEY_ARMED) |=> ##1 $stable(src_q);
   endproperty
   a_unkeyed: assert property (p_unkeyed) else $error("unkeyed write took effect");

   property p_no_resv;
      @(posedge clock) disable iff (!arst_n)
      src_q[1:0] != 2'h3;
   endproperty
   a_no_resv: assert property (p_no_resv) else $error("reserved source active");

endmodule : kps_top
`default_nettype wire

// ### dv/kps_tb.sv
// Self-checking testbench of the keyed loop-source and status block
`timescale 1ns/10ps
`default_nettype none
`include "kps_consts.svh"

module tb;
   // ==========================================================
   // Signals
   logic        clock;
   logic        arst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        crystal_input_pin;
   logic        pll_lock_raw;
   logic [1:0]  pll_ref_sel;
   logic [7:0]  power_control;
   logic        pll_lock_late;
   logic        irq;
   int          bad_count;
   int          samples_checked;
   int          seed;
   logic        rd_pend;
   logic [31:0] exp_q[$];
   logic [31:0] codes[4];
   logic [31:0] src;
   logic [31:0] pk;
   logic        x;

   // ==========================================================
   // Design under test, short lock bound
   kps_top #(.LOCK_CYCLES(50)) DUT (
      .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .crystal_input_pin(crystal_input_pin), .pll_lock_raw(pll_lock_raw),
      .pll_ref_sel(pll_ref_sel), .power_control(power_control),
      .pll_lock_late(pll_lock_late), .irq(irq));

   // Clock generator
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ==========================================================
   // Verdict and comparison
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // ==========================================================
   // Bus master
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         $display("wrong value hreadyout expected 1 seen %b", hreadyout);
         finish_test();
      end
   endtask : wait_rdy

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic keyed(input logic [31:0] pa, pv, ra, rv, qa, qv);
      wr(pa, pv);
      wr(ra, rv);
      wr(qa, qv);
   endtask : keyed

   // Read data monitor, takes oldest expectation
   always @(posedge clock) begin
      if (rd_pend && hreadyout === 1'b1) begin
         chk("hrdata", exp_q.pop_front(), hrdata);
         chk("hresp", 32'h0, {31'h0, hresp});
         rd_pend = 1'b0;
      end
      if (hsel === 1'b1 && hreadyout === 1'b1 && htrans[1] === 1'b1 && hwrite === 1'b0) begin
         rd_pend = 1'b1;
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'hE05E;
      bad_count = 0;
      samples_checked = 0;
      rd_pend = 1'b0;
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      crystal_input_pin = 1'b0;
      pll_lock_raw = 1'b0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      // Reset values, key registers and a hole
      rd(`KPS_ADDR_LOCK_STATUS, 32'h0);
      rd(`KPS_ADDR_SRC_SELECT, 32'h0);
      rd(`KPS_ADDR_POWER_CONTROL, 32'h79);
      rd(`KPS_ADDR_SRC_PREKEY, 32'h0);
      rd(`KPS_ADDR_SRC_POSTKEY, 32'h0);
      rd(32'hFFFF0424, 32'h0);
      chk("power_control", 32'h79, {24'h0, power_control});
      // Precision input enabled before the precision source is chosen
      keyed(`KPS_ADDR_POWER_PREKEY, `KPS_KEY_POWER_PRE, `KPS_ADDR_POWER_CONTROL, 32'hF9,
            `KPS_ADDR_POWER_POSTKEY, `KPS_KEY_POWER_POST);
      rd(`KPS_ADDR_POWER_CONTROL, 32'hF9);
      // Every source code, reserved last
      codes = '{32'h01, 32'h00, 32'h02, 32'h03};
      src = 32'h0;
      foreach (codes[i]) begin
         keyed(`KPS_ADDR_SRC_PREKEY, `KPS_KEY_SRC_PRE, `KPS_ADDR_SRC_SELECT, codes[i],
               `KPS_ADDR_SRC_POSTKEY, `KPS_KEY_SRC_POST);
         if (codes[i][1:0] != 2'h3) src = codes[i];
         rd(`KPS_ADDR_SRC_SELECT, src);
         chk("pll_ref_sel", src, {30'h0, pll_ref_sel});
      end
      // Broken sequences: no pre-key, wrong pre, wrong post, repeated write
      for (int i = 0; i < 4; i++) begin
         pk = $random(seed);
         if (pk == `KPS_KEY_SRC_PRE) pk = pk ^ 32'h1;
         if (i != 0) wr(`KPS_ADDR_SRC_PREKEY, (i == 1) ? pk : `KPS_KEY_SRC_PRE);
         wr(`KPS_ADDR_SRC_SELECT, 32'h1);
         if (i == 3) wr(`KPS_ADDR_SRC_SELECT, 32'h1);
         wr(`KPS_ADDR_SRC_POSTKEY, (i == 2) ? 32'h155 : `KPS_KEY_SRC_POST);
         rd(`KPS_ADDR_SRC_SELECT, 32'h2);
      end
      // Keyed full power-down, then a wrong post-key
      keyed(`KPS_ADDR_POWER_PREKEY, `KPS_KEY_POWER_PRE, `KPS_ADDR_POWER_CONTROL, 32'h0,
            `KPS_ADDR_POWER_POSTKEY, `KPS_KEY_POWER_POST);
      rd(`KPS_ADDR_SRC_PREKEY, 32'h0);
      rd(`KPS_ADDR_POWER_CONTROL, 32'h0);
      keyed(`KPS_ADDR_POWER_PREKEY, `KPS_KEY_POWER_PRE, `KPS_ADDR_POWER_CONTROL, 32'h79,
            `KPS_ADDR_POWER_POSTKEY, 32'hF5);
      rd(`KPS_ADDR_POWER_CONTROL, 32'h0);
      chk("power_control", 32'h0, {24'h0, power_control});
      // Lock rises, crystal level followed live
      pll_lock_raw <= 1'b1;
      repeat (6) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         pk = $random(seed);
         x = pk[0];
         crystal_input_pin <= x;
         repeat (6) @(posedge clock);
         rd(`KPS_ADDR_LOCK_STATUS, {29'h0, x, 2'h2});
      end
      crystal_input_pin <= 1'b0;
      // Lock loss, mask and one-to-clear
      pll_lock_raw <= 1'b0;
      repeat (6) @(posedge clock);
      rd(`KPS_ADDR_LOCK_STATUS, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      wr(`KPS_ADDR_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clock);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`KPS_ADDR_LOCK_STATUS, 32'hFFFFFFFE);
      rd(`KPS_ADDR_LOCK_STATUS, 32'h1);
      wr(`KPS_ADDR_LOCK_STATUS, 32'h1);
      rd(`KPS_ADDR_LOCK_STATUS, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      // Lock bound: relock, clear, then stay unlocked past it
      pll_lock_raw <= 1'b1;
      repeat (8) @(posedge clock);
      wr(`KPS_ADDR_LOCK_LATE, 32'h1);
      rd(`KPS_ADDR_LOCK_LATE, 32'h0);
      chk("pll_lock_late", 32'h0, {31'h0, pll_lock_late});
      pll_lock_raw <= 1'b0;
      repeat (30) @(posedge clock);
      rd(`KPS_ADDR_LOCK_LATE, 32'h0);
      repeat (40) @(posedge clock);
      rd(`KPS_ADDR_LOCK_LATE, 32'h1);
      chk("pll_lock_late", 32'h1, {31'h0, pll_lock_late});
      repeat (2) @(posedge clock);
      finish_test();
   end
endmodule : tb
`default_nettype wire
